// *** common/flash_id_pkg.sv ***
// Shared constants and carrier types for the flash ID and mode command logic
package flash_id_pkg;

    // ****
    // Opcodes
    // ****
    localparam logic [7:0] OP_RELEASE    = 8'hab;
    localparam logic [7:0] OP_MFR_SINGLE = 8'h90;
    localparam logic [7:0] OP_MFR_DUAL   = 8'h92;
    localparam logic [7:0] OP_MFR_QUAD   = 8'h94;
    localparam logic [7:0] OP_STD_ID     = 8'h9f;
    localparam logic [7:0] OP_QUAD_ON    = 8'h38;
    localparam logic [7:0] OP_QUAD_OFF   = 8'hff;

    // ****
    // Frame layout counts, in bits taken from the host
    // ****
    localparam logic [5:0] OPCODE_BITS  = 6'h08;
    localparam logic [5:0] DUMMY3_BITS  = 6'h18; // Three dummy bytes
    localparam logic [5:0] ADDR_BITS    = 6'h18; // 24-bit address
    localparam logic [5:0] DUAL_BITS    = 6'h20; // Address plus mode byte
    localparam logic [5:0] QUAD_BITS    = 6'h30; // Address, mode, dummy
    localparam logic [23:0] ADDR_SWAP   = 24'h000001;

    // ****
    // Output pattern lengths and lane widths
    // ****
    localparam logic [4:0] PLEN_ONE   = 5'h08;
    localparam logic [4:0] PLEN_TWO   = 5'h10;
    localparam logic [4:0] PLEN_THREE = 5'h18;
    localparam logic [2:0] LANE_ONE   = 3'h1;
    localparam logic [2:0] LANE_TWO   = 3'h2;
    localparam logic [2:0] LANE_FOUR  = 3'h4;

    // ****
    // Reset values
    // ****
    localparam logic RST_QUAD_MODE = 1'b0; // Power-up in standard mode
    localparam logic RST_DPD       = 1'b0;

    // ****
    // Timing
    // ****
    localparam int CLK_PERIOD_NS   = 20;
    localparam int RELEASE_WAKE_NS = 3000; // Plain default figure
    // Least time, so round up to whole cycles
    localparam int RELEASE_WAKE_CYCLES =
        (RELEASE_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****
    // Carrier types
    // ****
    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] io;
    } pin_in_t;

    typedef struct packed {
        logic [3:0] io_out;
        logic [3:0] io_oe;
    } pin_out_t;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_OPCODE,
        PH_ADDR,
        PH_OUT,
        PH_SKIP
    } phase_t;

endpackage

// *** hdl/pin_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // Asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    // First stage feeds only the second stage
    always_comb begin
        nxt_st.stage1 = d;
        nxt_st.stage2 = st_ff.stage1;
    end

    // Reset to chip-select high so no frame is seen during reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.stage2;

endmodule // pin_sync

`default_nettype wire

// *** hdl/wake_timer.sv ***
// Counts out the wake time after a release from deep power-down
`timescale 1ns/1ps
`default_nettype none

module wake_timer #(
    parameter int CYCLES = 150
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Start pulse in, done pulse out
    input  wire logic start,
    output logic      done
);

    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          run;
        logic          done;
    } timer_state_t;

    timer_state_t st_ff;
    timer_state_t nxt_st;

    // Load on start, pulse done when the count reaches one
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        if (start) begin
            nxt_st.count = CW'(CYCLES);
            nxt_st.run   = 1'b1;
        end else if (st_ff.run) begin
            nxt_st.count = st_ff.count - 1'b1;
            if (st_ff.count == CW'(1)) begin
                nxt_st.run  = 1'b0;
                nxt_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done = st_ff.done;

endmodule // wake_timer

`default_nettype wire

// *** hdl/flash_id_cmd.sv ***
// Serial flash command logic for wake, identification and mode switching
`timescale 1ns/1ps
`default_nettype none

// Function
// - Release opcode wakes device after wake time
// - Legacy ID only in standard serial mode
// - Legacy ID after three dummy bytes, MSB first
// - Legacy ID repeats until select rises
// - Release opcode ignored while busy
// - Single-line maker/device ID after zero address
// - Address one swaps the two ID bytes
// - Maker/device ID bytes alternate until select rises
// - Dual-line form uses two lanes
// - Quad-line form uses four lanes
// - Standard ID gives maker, type, capacity bytes
// - Standard ID repeats until select rises
// - Only quad enable opcode enters quad mode
// - Quad enable ignored when enable bit clear
// - Power-up in standard serial mode
// - Entering quad mode keeps latch, suspend, wrap
// - Quad disable returns to standard, keeps state
// - Power-down accepts only the release opcode
module flash_id_cmd
    import flash_id_pkg::*;
#(
    parameter logic [7:0] MFR_ID      = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEVICE_ID   = 8'h3c, // Arbitrary value
    parameter logic [7:0] MEM_TYPE_ID = 8'h42, // Arbitrary value
    parameter logic [7:0] CAPACITY_ID = 8'h18, // Arbitrary value
    parameter int         WAKE_CYCLES = flash_id_pkg::RELEASE_WAKE_CYCLES
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    // Serial pins, split into input, output and enable
    input  wire flash_id_pkg::pin_in_t  pins_in,
    output flash_id_pkg::pin_out_t      pins_out,
    // Status from the rest of the device, same clock
    input  wire logic                   busy,
    input  wire logic                   quad_enable_bit,
    input  wire logic                   dpd_enter,
    // Mode flags
    output logic                        quad_command_mode,
    output logic                        deep_power_down
);
    import flash_id_pkg::*;

    // ****
    // State
    // ****
    typedef struct packed {
        phase_t     phase;
        logic [7:0] opcode;
        logic [5:0] count;
        logic [5:0] need;
        logic [23:0] addr;
        logic [2:0] lanes_in;
        logic [2:0] lanes_out;
        logic       mfr_cmd;
        logic [23:0] pat;
        logic [4:0] plen;
        logic       quad_mode;
        logic       dpd;
        logic       release_pend;
        logic       wake_go;
        logic       sck_q;
        pin_out_t   pins;
    } core_state_t;

    core_state_t st_ff;
    core_state_t nxt_st;
    pin_in_t     pins_s;
    logic        wake_done;
    logic        sck_rise;
    logic        sck_fall;
    logic [7:0]  op_next;
    logic [5:0]  cnt_next;
    logic [23:0] addr_next;

    // ****
    // Pin synchroniser and wake timer
    // ****
    pin_sync #(
        .WIDTH ($bits(pin_in_t))
    ) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .d        (pins_in),
        .q        (pins_s)
    );

    wake_timer #(
        .CYCLES (WAKE_CYCLES)
    ) u_wake (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (st_ff.wake_go),
        .done     (wake_done)
    );

    // ****
    // Helpers
    // ****

    // Rotate the pattern left by n bits in its active length,
    // so a read keeps cycling through its bytes for as long as the
    // host keeps clocking
    function automatic logic [23:0] rot_pat(input logic [23:0] p,
                                            input logic [4:0]  len,
                                            input logic [2:0]  n);
        logic [23:0] r;
        r = p;
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < n) begin
                if (len == PLEN_ONE) begin
                    r = {r[22:16], r[23], 16'h0000};
                end else if (len == PLEN_TWO) begin
                    r = {r[22:8], r[23], 8'h00};
                end else begin
                    r = {r[22:0], r[23]};
                end
            end
        end
        return r;
    endfunction

    // Shift host bits in, MSB first, on the lanes in use
    function automatic logic [23:0] shift_in(input logic [23:0] v,
                                             input logic [3:0]  io,
                                             input logic [2:0]  n);
        logic [23:0] r;
        r = v;
        if (n == LANE_FOUR) begin
            r = {v[19:0], io[3:0]};
        end else if (n == LANE_TWO) begin
            r = {v[21:0], io[1:0]};
        end else begin
            r = {v[22:0], io[0]};
        end
        return r;
    endfunction

    // Edges of the synchronised serial clock, sampled in core_clk
    assign sck_rise = pins_s.sck & ~st_ff.sck_q;
    assign sck_fall = ~pins_s.sck & st_ff.sck_q;

    // Opcode and address shifters; the opcode arrives on four lanes
    // in quad command mode, one lane otherwise
    always_comb begin
        op_next   = 8'h00;
        cnt_next  = st_ff.count;
        addr_next = st_ff.addr;
        if (st_ff.phase == PH_OPCODE) begin
            if (st_ff.quad_mode) begin
                op_next  = {st_ff.opcode[3:0], pins_s.io[3:0]};
                cnt_next = st_ff.count + 6'(LANE_FOUR);
            end else begin
                op_next  = {st_ff.opcode[6:0], pins_s.io[0]};
                cnt_next = st_ff.count + 6'(LANE_ONE);
            end
        end else begin
            cnt_next = st_ff.count + 6'(st_ff.lanes_in);
            if (st_ff.count < ADDR_BITS) begin
                addr_next = shift_in(st_ff.addr, pins_s.io,
                                     st_ff.lanes_in);
            end
        end
    end

    // ****
    // Command sequencing
    // ****

    // One frame per chip-select low period. Host bits are taken on
    // rising serial clock edges, ID bits leave on falling edges. The
    // write enable latch, suspend state and wrap length live outside
    // this block and are never touched by a mode change.
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.sck_q   = pins_s.sck;
        nxt_st.wake_go = 1'b0;

        // Wake time over: normal operation resumes
        if (wake_done) begin
            nxt_st.dpd = 1'b0;
        end
        // Entry is decoded elsewhere; it lands here as a pulse
        if (dpd_enter) begin
            nxt_st.dpd = 1'b1;
        end

        if (pins_s.cs_n) begin
            // Select high ends the command, frees lines
            nxt_st.phase       = PH_IDLE;
            nxt_st.pins.io_oe  = 4'h0;
            nxt_st.pins.io_out = 4'h0;
            if (st_ff.release_pend) begin
                // Wake starts at select rise; the host must leave
                // select high until it is over
                nxt_st.release_pend = 1'b0;
                nxt_st.wake_go      = 1'b1;
            end
        end else begin
            unique case (st_ff.phase)
                PH_IDLE: begin
                    nxt_st.phase  = PH_OPCODE;
                    nxt_st.count  = 6'h00;
                    nxt_st.opcode = 8'h00;
                end

                PH_OPCODE: begin
                    if (sck_rise) begin
                        nxt_st.opcode = op_next;
                        nxt_st.count  = cnt_next;
                        if (cnt_next == OPCODE_BITS) begin
                            nxt_st.count = 6'h00;
                            nxt_st.addr  = 24'h000000;
                            nxt_st.phase = PH_SKIP;
                            // Flags checked before any action
                            if (st_ff.dpd) begin
                                // Only release, and not while busy
                                if (op_next == OP_RELEASE && !busy) begin
                                    nxt_st.release_pend = 1'b1;
                                end
                            end else begin
                                unique case (op_next)
                                    OP_RELEASE: begin
                                        // Busy or quad mode: no ID
                                        if (!busy && !st_ff.quad_mode) begin
                                            nxt_st.phase     = PH_ADDR;
                                            nxt_st.need      = DUMMY3_BITS;
                                            nxt_st.lanes_in  = LANE_ONE;
                                            nxt_st.lanes_out = LANE_ONE;
                                            nxt_st.mfr_cmd   = 1'b0;
                                            // Same byte each time
                                            nxt_st.pat  = {DEVICE_ID, 16'h0000};
                                            nxt_st.plen = PLEN_ONE;
                                        end
                                    end
                                    OP_MFR_SINGLE: begin
                                        nxt_st.phase   = PH_ADDR;
                                        nxt_st.mfr_cmd = 1'b1;
                                        if (st_ff.quad_mode) begin
                                            nxt_st.need      = ADDR_BITS;
                                            nxt_st.lanes_in  = LANE_FOUR;
                                            nxt_st.lanes_out = LANE_FOUR;
                                        end else begin
                                            nxt_st.need      = ADDR_BITS;
                                            nxt_st.lanes_in  = LANE_ONE;
                                            nxt_st.lanes_out = LANE_ONE;
                                        end
                                    end
                                    OP_MFR_DUAL: begin
                                        if (!st_ff.quad_mode) begin
                                            // Address and mode byte on
                                            // two lanes
                                            nxt_st.phase     = PH_ADDR;
                                            nxt_st.mfr_cmd   = 1'b1;
                                            nxt_st.need      = DUAL_BITS;
                                            nxt_st.lanes_in  = LANE_TWO;
                                            nxt_st.lanes_out = LANE_TWO;
                                        end
                                    end
                                    OP_MFR_QUAD: begin
                                        if (!st_ff.quad_mode) begin
                                            // Address, mode and dummy on
                                            // four lanes
                                            nxt_st.phase     = PH_ADDR;
                                            nxt_st.mfr_cmd   = 1'b1;
                                            nxt_st.need      = QUAD_BITS;
                                            nxt_st.lanes_in  = LANE_FOUR;
                                            nxt_st.lanes_out = LANE_FOUR;
                                        end
                                    end
                                    OP_STD_ID: begin
                                        // Maker, type, capacity
                                        nxt_st.phase = PH_OUT;
                                        nxt_st.pat   = {MFR_ID, MEM_TYPE_ID,
                                                        CAPACITY_ID};
                                        nxt_st.plen  = PLEN_THREE;
                                        nxt_st.lanes_out = st_ff.quad_mode ?
                                                           LANE_FOUR : LANE_ONE;
                                    end
                                    OP_QUAD_ON: begin
                                        // Needs the enable bit
                                        if (!st_ff.quad_mode && quad_enable_bit) begin
                                            nxt_st.quad_mode = 1'b1;
                                        end
                                    end
                                    OP_QUAD_OFF: begin
                                        if (st_ff.quad_mode) begin
                                            nxt_st.quad_mode = 1'b0;
                                        end
                                    end
                                    default: begin
                                        // Left to other decoders
                                        nxt_st.phase = PH_SKIP;
                                    end
                                endcase
                            end
                        end
                    end
                end

                PH_ADDR: begin
                    if (sck_rise) begin
                        nxt_st.addr  = addr_next;
                        nxt_st.count = cnt_next;
                        if (cnt_next >= st_ff.need) begin
                            nxt_st.phase = PH_OUT;
                            if (st_ff.mfr_cmd) begin
                                // Address one puts the device byte
                                // first
                                if (addr_next == ADDR_SWAP) begin
                                    nxt_st.pat = {DEVICE_ID, MFR_ID, 8'h00};
                                end else begin
                                    nxt_st.pat = {MFR_ID, DEVICE_ID, 8'h00};
                                end
                                nxt_st.plen = PLEN_TWO;
                            end
                        end
                    end
                end

                PH_OUT: begin
                    // Drive the top bits, then rotate so the pattern
                    // repeats without end
                    if (sck_fall) begin
                        nxt_st.pat = rot_pat(st_ff.pat, st_ff.plen,
                                             st_ff.lanes_out);
                        if (st_ff.lanes_out == LANE_FOUR) begin
                            nxt_st.pins.io_out = st_ff.pat[23:20];
                            nxt_st.pins.io_oe  = 4'hf;
                        end else if (st_ff.lanes_out == LANE_TWO) begin
                            nxt_st.pins.io_out = {2'b00, st_ff.pat[23:22]};
                            nxt_st.pins.io_oe  = 4'h3;
                        end else begin
                            nxt_st.pins.io_out = {2'b00, st_ff.pat[23],
                                                  1'b0};
                            nxt_st.pins.io_oe  = 4'h2;
                        end
                    end
                end

                PH_SKIP: begin
                    // Ignored frame: wait for select to rise
                    nxt_st.phase = PH_SKIP;
                end

                default: begin
                    nxt_st.phase = PH_SKIP;
                end
            endcase
        end
    end

    // ****
    // Registers
    // ****

    // Reset leaves standard serial mode and lines released
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff           <= '0;
            st_ff.phase     <= PH_IDLE;
            st_ff.quad_mode <= RST_QUAD_MODE;
            st_ff.dpd       <= RST_DPD;
            st_ff.sck_q     <= 1'b1;
            st_ff.lanes_in  <= LANE_ONE;
            st_ff.lanes_out <= LANE_ONE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign pins_out          = st_ff.pins;
    assign quad_command_mode = st_ff.quad_mode;
    assign deep_power_down   = st_ff.dpd;

endmodule // flash_id_cmd

`default_nettype wire

// *** testbench/flash_id_cmd_assertions.sv ***
// Checker for the flash ID and mode command logic
`timescale 1ns/1ps
`default_nettype none
module flash_id_cmd_assertions
    import flash_id_pkg::*;
#(parameter int WAKE_CYCLES = 5) (
    // Clock and reset
    input wire logic                   core_clk,
    input wire logic                   reset,
    // Pins
    input wire flash_id_pkg::pin_in_t  pins_in,
    input wire flash_id_pkg::pin_out_t pins_out,
    // Status and mode flags
    input wire logic                   busy,
    input wire logic                   quad_enable_bit,
    input wire logic                   dpd_enter,
    input wire logic                   quad_command_mode,
    input wire logic                   deep_power_down
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Select seen high long enough to flush the synchroniser
    sequence cs_idle; pins_in.cs_n [*6]; endsequence
    a_power_up_std: assert property (disable iff (1'b0) $fell(reset)
        |-> !quad_command_mode && !deep_power_down) else $error("mode");
    a_enter_sleep: assert property (dpd_enter |=> deep_power_down)
        else $error("no sleep");
    a_sleep_quiet: assert property (deep_power_down |-> !pins_out.io_oe)
        else $error("drive in sleep");
    a_wake_wait: assert property ($fell(deep_power_down)
        |-> $past(pins_in.cs_n, WAKE_CYCLES)) else $error("early wake");
    a_quad_needs_qe: assert property ($rose(quad_command_mode)
        |-> $past(quad_enable_bit)) else $error("quad without enable");
    a_lane_shape: assert property (pins_out.io_oe inside
        {4'h0, 4'h2, 4'h3, 4'hf}) else $error("lane set");
    a_quad_lanes: assert property (quad_command_mode && |pins_out.io_oe
        |-> &pins_out.io_oe) else $error("quad lanes");
    a_end_on_rise: assert property (cs_idle |-> !pins_out.io_oe)
        else $error("drive after select");
endmodule // flash_id_cmd_assertions
bind flash_id_cmd flash_id_cmd_assertions #(.WAKE_CYCLES(WAKE_CYCLES)) chk (
    .core_clk(core_clk), .reset(reset), .pins_in(pins_in),
    .pins_out(pins_out), .busy(busy), .quad_enable_bit(quad_enable_bit),
    .dpd_enter(dpd_enter), .quad_command_mode(quad_command_mode),
    .deep_power_down(deep_power_down));
`default_nettype wire

// *** testbench/flash_host_model.sv ***
// Host controller model that frames commands on the serial pins
`timescale 1ns/1ps
`default_nettype none
module flash_host_model
    import flash_id_pkg::*;
(
    // Clock
    input wire logic                   core_clk,
    // Serial pins
    output var flash_id_pkg::pin_in_t  pins,
    input wire flash_id_pkg::pin_out_t pout
);
    logic drove; // Device drove a line in the last frame
    // Six cycles a phase keeps the synchroniser well inside its limits
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Opcode on ol lanes, the rest on dl lanes, then nrx read clocks
    task automatic frame(input logic [55:0] tx, input int nb, ol, dl, nrx,
                         output logic [47:0] rx);
        int i;
        int w;
        logic [3:0] v;
        rx = '0;
        drove = 1'b0;
        pins.cs_n = 1'b0;
        tick(6);
        for (i = 0; i < nb; i += w) begin // MSB first
            w = (i < 8) ? ol : dl;
            pins.io = tx[55 - i -: 4] >> (4 - w);
            tick(6);
            pins.sck = 1'b1;
            tick(6);
            pins.sck = 1'b0;
        end
        for (i = 0; i < nrx; i++) begin
            pins.io = ~pins.io; // Released lines must not hold a value
            tick(6);
            drove |= |pout.io_oe;
            v = (dl == 1) ? 4'(pout.io_out[1]) : pout.io_out;
            rx = (rx << dl) | 48'(v & 4'((1 << dl) - 1));
            pins.sck = 1'b1;
            tick(6);
            pins.sck = 1'b0;
        end
        tick(6);
        pins.cs_n = 1'b1; // select stays high before the next frame
        tick(10);
    endtask
    initial begin
        pins = '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
    end
endmodule // flash_host_model
`default_nettype wire

// *** testbench/test_flash_id_cmd.sv ***
// Self-checking bench for the flash ID and mode command logic
`timescale 1ns/1ps
`default_nettype none
module test_flash_id_cmd;
    import flash_id_pkg::*;
    localparam logic [7:0] MFR = 8'h5a, DEV = 8'h3c; // Arbitrary values
    localparam logic [7:0] TYP = 8'h42, CAP = 8'h18; // Arbitrary values
    logic        core_clk, reset, busy, qe, dpd_enter, qmode, dpd;
    pin_in_t     pins_in;
    pin_out_t    pins_out;
    logic [47:0] rx;
    logic [31:0] seed = 32'h00012e97;
    logic [7:0]  op[3] = '{OP_MFR_SINGLE, OP_MFR_DUAL, OP_MFR_QUAD};
    int          nb[3] = '{32, 40, 56}, ln[3] = '{1, 2, 4};
    int          miscompares = 0, checks_done = 0, i;
    flash_id_cmd #(.MFR_ID(MFR), .DEVICE_ID(DEV), .MEM_TYPE_ID(TYP),
        .CAPACITY_ID(CAP), .WAKE_CYCLES(5)) flash_id_cmd_inst (
        .core_clk(core_clk), .reset(reset), .pins_in(pins_in),
        .pins_out(pins_out), .busy(busy), .quad_enable_bit(qe),
        .dpd_enter(dpd_enter), .quad_command_mode(qmode),
        .deep_power_down(dpd));
    flash_host_model flash_host_model_inst (.core_clk(core_clk),
        .pins(pins_in), .pout(pins_out));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // Alternating ID bytes, device byte first when the address is one
    function automatic logic [47:0] pair(input logic sw);
        return sw ? {16'h0, DEV, MFR, DEV, MFR} : {16'h0, MFR, DEV, MFR, DEV};
    endfunction
    task automatic cmp_d(input logic [47:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_f(input logic got, exp);
        cmp_d({47'h0, got}, {47'h0, exp});
    endtask
    task automatic t(input int n);
        flash_host_model_inst.tick(n);
    endtask
    task automatic f(input logic [55:0] tx, input int nb, ol, dl, nrx);
        flash_host_model_inst.frame(tx, nb, ol, dl, nrx, rx);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Watchdog: a hang counts as a mismatch
    initial begin
        #2000000;
        miscompares++;
        stop_test;
    end
    initial begin
        {reset, busy, qe, dpd_enter} = 4'h8;
        t(6);
        reset = 1'b0;
        t(4);
        f({OP_STD_ID, 48'h0}, 8, 1, 1, 48);
        cmp_d(rx, {MFR, TYP, CAP, MFR, TYP, CAP});
        cmp_f(qmode, 1'b0);
        f({OP_RELEASE, seed[23:0], 24'h0}, 32, 1, 1, 16);
        cmp_d(rx, {32'h0, DEV, DEV});
        $display("test ids done");
        // All three lane widths, both orders, random mode and dummy bits
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            f({op[k%3], 23'h0, k > 2, seed[23:0]}, nb[k%3], 1, ln[k%3],
              32 / ln[k%3]);
            cmp_d(rx, pair(k > 2));
        end
        $display("test pairs done");
        dpd_enter = 1'b1;
        t(1);
        dpd_enter = 1'b0;
        cmp_f(dpd, 1'b1);
        f({OP_STD_ID, 48'h0}, 8, 1, 1, 8);
        cmp_f(flash_host_model_inst.drove, 1'b0);
        busy = 1'b1;
        f({OP_RELEASE, 48'h0}, 8, 1, 1, 0);
        t(20);
        cmp_f(dpd, 1'b1);
        busy = 1'b0;
        f({OP_RELEASE, 48'h0}, 8, 1, 1, 0);
        for (i = 0; i < 40 && dpd !== 1'b0; i++) t(1);
        if (i == 40) begin
            miscompares++;
            stop_test;
        end
        $display("test sleep done");
        f({OP_QUAD_ON, 48'h0}, 8, 1, 1, 0);
        cmp_f(qmode, 1'b0);
        qe = 1'b1;
        f({OP_QUAD_ON, 48'h0}, 8, 1, 1, 0);
        cmp_f(qmode, 1'b1);
        f({OP_RELEASE, 48'h0}, 32, 4, 4, 4);
        cmp_f(flash_host_model_inst.drove, 1'b0);
        f({OP_MFR_SINGLE, 24'h1, 24'h0}, 32, 4, 4, 8);
        cmp_d(rx, pair(1'b1));
        f({OP_QUAD_OFF, 48'h0}, 8, 4, 4, 0);
        cmp_f(qmode, 1'b0);
        $display("test quad done");
        stop_test;
    end
endmodule // test_flash_id_cmd
`default_nettype wire
